/* File: core/pfc_host.sv */
// Host-side controller for a byte-wide parallel flash: reads, byte program,
// sector erase and chip erase with completion polling.
// Assumes the flash pins are wired directly and its inputs are synchronous to clk_sys_i.
//
// Overview of operation
// [RULE1] Each command write holds chip select low across the whole write strobe.
// [RULE2] Flash latches address when the later of strobe or select falls.
// [RULE3] Flash latches data when the earlier of strobe or select rises.
// [RULE4] Flash drives data only while select and output enable are both low.
// [RULE5] With select high the flash is deselected and in standby.
// [RULE6] Flash data pins float whenever select or output enable is high.
// [RULE7] Program single bytes only, and only inside a sector already erased.
// [RULE8] Byte program is three unlock writes then one address and data write.
// [RULE9] Flash finishes a byte program within thirty microseconds.
// [RULE10] Flash ignores commands while programming; only status reads are meaningful.
// [RULE11] The array is split into uniform four kilobyte erase sectors.
// [RULE12] Sector erase is six writes, last carrying sector code and sector address.
// [RULE13] Flash starts sector erase after the sixth write pulse.
// [RULE14] Chip erase is six writes, last writing chip code to the fixed address.
// [RULE15] Flash ignores commands while any erase runs.
// [RULE16] Status reporting starts at the rising strobe that launches the operation.
// [RULE17] On a done-looking status, read twice more; both must be valid.
// [RULE18] While programming the top bit reads inverted, then true when finished.
// [RULE19] The full byte reads valid one microsecond after the write completes.
// [RULE20] While erasing the top bit reads zero, then one when finished.
// [RULE21] Status is valid after the fourth or sixth rising write strobe.
// [RULE22] The second-highest bit toggles on each read while busy, starting at one.
// [RULE23] An invalid unlock cycle aborts the sequence back to read mode.
// [RULE24] Flash inhibits writes while output enable low, select high or strobe high.
// [RULE25] Poll to completion before any new command or ordinary read.
`timescale 1ns/1ps
module pfc_host #(
  parameter logic [pfc_pkg::ADDR_W-1:0] UNLOCK_ADDR2      = 16'h2aaa,
  parameter logic [pfc_pkg::DATA_W-1:0] UNLOCK_CODE1      = 8'haa,
  parameter logic [pfc_pkg::DATA_W-1:0] UNLOCK_CODE2      = 8'h55,
  parameter logic [pfc_pkg::DATA_W-1:0] PROG_CODE         = 8'ha0,
  parameter logic [pfc_pkg::DATA_W-1:0] ERASE_SETUP_CODE  = 8'h80,
  parameter int unsigned                ERASE_TIMEOUT_CYC = 1000000
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic                       req_i,
  input  wire pfc_pkg::pfc_op_t           op_i,
  input  wire logic [pfc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [pfc_pkg::DATA_W-1:0] wdata_i,
  output logic                            busy_o,
  output logic                            done_o,
  output logic                            err_o,
  output logic      [pfc_pkg::DATA_W-1:0] rdata_o,
  output logic                            flash_ce_n_o,
  output logic                            flash_oe_n_o,
  output logic                            flash_we_n_o,
  output logic      [pfc_pkg::ADDR_W-1:0] flash_addr_o,
  input  wire logic [pfc_pkg::DATA_W-1:0] flash_dq_i,
  output logic      [pfc_pkg::DATA_W-1:0] flash_dq_o,
  output logic                            flash_dq_oe_o
);
  import pfc_pkg::*;

  localparam int unsigned SECTOR_CNT = 2 ** SECT_W;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_SEQ    = 6'b000010,
    ST_POLL   = 6'b000100,
    ST_CONF   = 6'b001000,
    ST_SETTLE = 6'b010000,
    ST_FINAL  = 6'b100000
  } pfc_state_t;

  typedef struct packed {
    pfc_state_t            st;
    pfc_op_t               op;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [2:0]            idx;
    logic [TMO_W-1:0]      cnt;
    logic [1:0]            conf;
    logic                  first;
    logic                  prev_tog;
    logic [SECTOR_CNT-1:0] erased;
    logic                  bus_start;
    logic                  bus_wr;
    logic [ADDR_W-1:0]     bus_addr;
    logic [DATA_W-1:0]     bus_data;
    logic                  busy;
    logic                  done;
    logic                  err;
    logic [DATA_W-1:0]     rdata;
  } pfc_host_t;

  localparam pfc_host_t HOST_RESET = '{st: ST_IDLE, op: PFC_OP_READ, addr: '0, wdata: '0, idx: 3'h0,
                                       cnt: '0, conf: 2'h0, first: 1'b1, prev_tog: 1'b0,
                                       erased: '0, bus_start: 1'b0, bus_wr: 1'b0, bus_addr: '0,
                                       bus_data: '0, busy: 1'b0, done: 1'b0, err: 1'b0, rdata: '0};

  pfc_host_t         s_q;
  pfc_host_t         s_d;
  logic              bus_done;
  logic [DATA_W-1:0] bus_rdata;

  // ----------------------------------------------------------------------
  // Unlock and command words
  // ----------------------------------------------------------------------
  // Returns {address, data} of write cycle idx of the given operation.
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input pfc_op_t op, input logic [2:0] idx,
                                                        input logic [ADDR_W-1:0] a,
                                                        input logic [DATA_W-1:0] d);
    logic [ADDR_W+DATA_W-1:0] w;
    w = {CMD_ADDR_MAIN, UNLOCK_CODE1};
    unique case (idx)
      3'h1, 3'h4: w = {UNLOCK_ADDR2, UNLOCK_CODE2};
      3'h2:       w = (op == PFC_OP_PROG) ? {CMD_ADDR_MAIN, PROG_CODE} : {CMD_ADDR_MAIN, ERASE_SETUP_CODE};
      3'h3:       w = (op == PFC_OP_PROG) ? {a, d} : {CMD_ADDR_MAIN, UNLOCK_CODE1};   // RULE8
      3'h5:       w = (op == PFC_OP_SECTER) ? {a, CMD_SECTOR_ERASE}                   // RULE12
                                            : {CMD_ADDR_MAIN, CMD_CHIP_ERASE};        // RULE14
      default:    w = {CMD_ADDR_MAIN, UNLOCK_CODE1};
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------------
  // Status checks: the top bit must show the finished value and the toggling
  // bit must have stopped (two equal reads in a row) before a read counts.
  logic                  top_ok;
  logic                  stat_ok;
  logic [TMO_W-1:0]      tmo_lim;
  logic [SECT_W-1:0]     sect;
  logic [ADDR_W+DATA_W-1:0] word;

  always_comb begin
    s_d           = s_q;
    s_d.bus_start = 1'b0;
    s_d.done      = 1'b0;
    s_d.err       = 1'b0;
    sect          = s_q.addr[ADDR_W-1:SECT_ADDR_LSB];
    word          = seq_word(s_q.op, s_q.idx, s_q.addr, s_q.wdata);
    top_ok        = (s_q.op == PFC_OP_PROG) ? (bus_rdata[7] == s_q.wdata[7])   // RULE18
                                            : bus_rdata[7];                   // RULE20
    stat_ok       = top_ok && !s_q.first && (bus_rdata[6] == s_q.prev_tog);   // RULE22
    tmo_lim       = (s_q.op == PFC_OP_PROG) ? TMO_W'(PROG_MAX_CYC) : TMO_W'(ERASE_TIMEOUT_CYC);
    unique case (s_q.st)
      ST_IDLE: begin
        if (req_i) begin                                    // Taken only when idle. RULE25
          s_d.op    = op_i;
          s_d.addr  = addr_i;
          s_d.wdata = wdata_i;
          s_d.idx   = 3'h0;
          s_d.cnt   = '0;
          s_d.conf  = 2'h0;
          s_d.first = 1'b1;
          if (op_i == PFC_OP_READ) begin
            s_d.busy      = 1'b1;
            s_d.bus_start = 1'b1;
            s_d.bus_wr    = 1'b0;
            s_d.bus_addr  = addr_i;
            s_d.st        = ST_FINAL;
          end else if (op_i == PFC_OP_PROG && !s_q.erased[addr_i[ADDR_W-1:SECT_ADDR_LSB]]) begin
            s_d.done = 1'b1;                                // Refused: sector not erased. RULE7
            s_d.err  = 1'b1;
          end else begin
            s_d.busy      = 1'b1;
            s_d.bus_start = 1'b1;
            s_d.bus_wr    = 1'b1;
            s_d.bus_addr  = CMD_ADDR_MAIN;
            s_d.bus_data  = UNLOCK_CODE1;
            s_d.st        = ST_SEQ;
          end
        end
      end
      ST_SEQ: begin
        if (bus_done) begin
          s_d.bus_start = 1'b1;
          if (s_q.idx == ((s_q.op == PFC_OP_PROG) ? PROG_SEQ_LAST : ERASE_SEQ_LAST)) begin
            s_d.bus_wr   = 1'b0;                            // Poll from the launching edge on. RULE16
            s_d.bus_addr = s_q.addr;
            s_d.st       = ST_POLL;                         // RULE21
          end else begin
            s_d.idx      = s_q.idx + 3'h1;
            word         = seq_word(s_q.op, s_q.idx + 3'h1, s_q.addr, s_q.wdata);
            s_d.bus_addr = word[ADDR_W+DATA_W-1:DATA_W];
            s_d.bus_data = word[DATA_W-1:0];
          end
        end
      end
      ST_POLL, ST_CONF: begin
        s_d.cnt = s_q.cnt + TMO_W'(1);
        if (s_q.cnt >= tmo_lim) begin                       // Flash overran its limit. RULE9
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.err  = 1'b1;
          s_d.st   = ST_IDLE;
        end else if (bus_done) begin
          s_d.prev_tog  = bus_rdata[6];
          s_d.first     = 1'b0;
          s_d.bus_start = 1'b1;
          if (!stat_ok) begin
            s_d.conf = 2'h0;
            s_d.st   = ST_POLL;
          end else if (s_q.st == ST_POLL) begin
            s_d.st = ST_CONF;                               // Confirm with two more reads. RULE17
          end else if (s_q.conf != RECHECK_LAST) begin
            s_d.conf = s_q.conf + 2'h1;                     // RULE17
          end else if (s_q.op == PFC_OP_PROG) begin
            s_d.bus_start = 1'b0;
            s_d.cnt       = '0;
            s_d.st        = ST_SETTLE;
          end else begin
            s_d.bus_start = 1'b0;
            if (s_q.op == PFC_OP_CHIPER) begin
              s_d.erased = '1;
            end else begin
              s_d.erased[sect] = 1'b1;
            end
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st   = ST_IDLE;
          end
        end
      end
      ST_SETTLE: begin
        s_d.cnt = s_q.cnt + TMO_W'(1);
        if (s_q.cnt == TMO_W'(SETTLE_CYC - 1)) begin        // RULE19
          s_d.bus_start = 1'b1;
          s_d.st        = ST_FINAL;
        end
      end
      ST_FINAL: begin
        if (bus_done) begin
          s_d.rdata = bus_rdata;
          s_d.err   = (s_q.op == PFC_OP_PROG) && (bus_rdata != s_q.wdata);
          s_d.busy  = 1'b0;
          s_d.done  = 1'b1;
          s_d.st    = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= HOST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o  = s_q.busy;
  assign done_o  = s_q.done;
  assign err_o   = s_q.err;
  assign rdata_o = s_q.rdata;

  // ----------------------------------------------------------------------
  // Pin timing engine
  // ----------------------------------------------------------------------
  pfc_bus_cycle u_bus (
    .clk_sys_i     (clk_sys_i),
    .rst_i         (rst_i),
    .start_i       (s_q.bus_start),
    .wr_i          (s_q.bus_wr),
    .addr_i        (s_q.bus_addr),
    .data_i        (s_q.bus_data),
    .flash_dq_i    (flash_dq_i),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_oe_n_o  (flash_oe_n_o),
    .flash_we_n_o  (flash_we_n_o),
    .flash_addr_o  (flash_addr_o),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o),
    .rdata_o       (bus_rdata),
    .done_o        (bus_done)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Counts write strobes issued since the operation left idle.
  logic [2:0] ast_wr_cnt_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ast_wr_cnt_q <= 3'h0;
    end else if (s_q.st == ST_IDLE) begin
      ast_wr_cnt_q <= 3'h0;
    end else if ($rose(flash_we_n_o)) begin
      ast_wr_cnt_q <= ast_wr_cnt_q + 3'h1;
    end
  end

  AST_PROG_FOUR_WRITES: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE8
    (s_q.st == ST_SEQ && s_d.st == ST_POLL && s_q.op == PFC_OP_PROG) |-> ast_wr_cnt_q == 3'h4)
    else $error("Program polling began without exactly four write strobes.");
  AST_ERASE_SIX_WRITES: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE12
    (s_q.st == ST_SEQ && s_d.st == ST_POLL && s_q.op != PFC_OP_PROG) |-> ast_wr_cnt_q == 3'h6)
    else $error("Erase polling began without exactly six write strobes.");
  AST_SECTOR_LAST_WORD: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE12
    (s_q.bus_start && s_q.bus_wr && s_q.op == PFC_OP_SECTER && s_q.idx == 3'h5)
      |-> s_q.bus_data == 8'h30 && s_q.bus_addr == s_q.addr)
    else $error("Sector erase last write lacks its code or sector address.");
  AST_CHIP_LAST_WORD: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE14
    (s_q.bus_start && s_q.bus_wr && s_q.op == PFC_OP_CHIPER && s_q.idx == 3'h5)
      |-> s_q.bus_data == 8'h10 && s_q.bus_addr == 16'h5555)
    else $error("Chip erase last write has the wrong code or address.");
  AST_PROG_NEEDS_ERASE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE7
    (s_q.st == ST_IDLE && s_d.st == ST_SEQ && s_d.op == PFC_OP_PROG)
      |-> s_q.erased[s_d.addr[15:12]])
    else $error("Program launched into a sector not erased.");
  AST_BUSY_HOLDS_OP: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE25
    (busy_o && req_i) |=> $stable(s_q.op) && $stable(s_q.addr))
    else $error("A request was taken while an operation was running.");
  AST_CONFIRM_BEFORE_DONE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE17
    (s_q.st == ST_CONF && (s_d.st == ST_SETTLE || (s_d.st == ST_IDLE && !s_d.err)))
      |-> s_q.conf == 2'h1 && bus_done)
    else $error("Completion taken without two confirming status reads.");

  // Counts settling cycles on its own, so a broken sequencer counter cannot hide.
  logic [3:0] ast_settle_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ast_settle_q <= 4'h0;
    end else if (s_q.st == ST_SETTLE) begin
      ast_settle_q <= ast_settle_q + 4'h1;
    end else begin
      ast_settle_q <= 4'h0;
    end
  end

  AST_SETTLE_BEFORE_VERIFY: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE19
    (s_q.st == ST_SETTLE && s_d.st != ST_SETTLE)
      |-> ast_settle_q == 4'(SETTLE_CYC - 1) && s_d.st == ST_FINAL)
    else $error("Verify read did not wait the settling interval.");
  AST_SETTLE_NOT_LONGER: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE19
    (s_q.st == ST_SETTLE) |-> ast_settle_q <= 4'(SETTLE_CYC - 1))
    else $error("Settling wait ran past its interval.");
endmodule

/* File: shared/pfc_pkg.sv */
// Constants and types shared by the parallel flash host controller.
// Assumes a 10 MHz system clock and a byte-wide flash with 64K addresses.
package pfc_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned SECT_ADDR_LSB = 12;  // 4 KByte erase sectors.
  localparam int unsigned SECT_W        = ADDR_W - SECT_ADDR_LSB;

  // ----------------------------------------------------------------------
  // Timing, in printed units and in clock cycles
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_MAX_US   = 30;   // Longest byte program time.
  localparam int unsigned PROG_MAX_CYC  = (PROG_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_US     = 1;    // Full byte valid after completion.
  localparam int unsigned SETTLE_CYC    = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RD_ACCESS_NS  = 70;
  localparam int unsigned RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_LOW_CYC    = 1;
  localparam int unsigned TMO_W         = 24;

  // ----------------------------------------------------------------------
  // Command codes and sequence shape
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CMD_ADDR_MAIN    = 16'h5555;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE   = 8'h10;
  localparam logic [2:0]        PROG_SEQ_LAST    = 3'h3;  // Four write cycles.
  localparam logic [2:0]        ERASE_SEQ_LAST   = 3'h5;  // Six write cycles.
  localparam logic [1:0]        RECHECK_LAST     = 2'h1;  // Two extra confirming reads.

  typedef enum logic [1:0] {
    PFC_OP_READ   = 2'h0,
    PFC_OP_PROG   = 2'h1,
    PFC_OP_SECTER = 2'h2,
    PFC_OP_CHIPER = 2'h3
  } pfc_op_t;

endpackage

/* File: core/pfc_bus_cycle.sv */
// One asynchronous flash bus cycle (read or write) built from the system clock.
// Assumes the caller waits for done_o before starting the next cycle.
`timescale 1ns/1ps
module pfc_bus_cycle #(
  parameter int unsigned STROBE_CYC = pfc_pkg::WE_LOW_CYC,
  parameter int unsigned ACCESS_CYC = pfc_pkg::RD_ACCESS_CYC
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic                       start_i,
  input  wire logic                       wr_i,
  input  wire logic [pfc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [pfc_pkg::DATA_W-1:0] data_i,
  input  wire logic [pfc_pkg::DATA_W-1:0] flash_dq_i,
  output logic                            flash_ce_n_o,
  output logic                            flash_oe_n_o,
  output logic                            flash_we_n_o,
  output logic      [pfc_pkg::ADDR_W-1:0] flash_addr_o,
  output logic      [pfc_pkg::DATA_W-1:0] flash_dq_o,
  output logic                            flash_dq_oe_o,
  output logic      [pfc_pkg::DATA_W-1:0] rdata_o,
  output logic                            done_o
);
  import pfc_pkg::*;

  typedef enum logic [3:0] {
    BC_IDLE  = 4'b0001,
    BC_SETUP = 4'b0010,
    BC_ACT   = 4'b0100,
    BC_HOLD  = 4'b1000
  } pfc_bc_state_t;

  typedef struct packed {
    pfc_bc_state_t     st;
    logic [3:0]        cnt;
    logic              wr;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic              dq_oe;
    logic [DATA_W-1:0] rdata;
    logic              done;
  } pfc_bc_t;

  localparam pfc_bc_t BC_RESET = '{st: BC_IDLE, cnt: 4'h0, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                                   we_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0, rdata: '0,
                                   done: 1'b0};

  pfc_bc_t s_q;
  pfc_bc_t s_d;

  // ----------------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------------
  // Chip select falls one cycle before the strobe and rises one cycle after it,
  // so the strobe edges alone mark where the flash latches address and data.
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      BC_IDLE: begin
        if (start_i) begin
          s_d.addr  = addr_i;
          s_d.dq    = data_i;
          s_d.wr    = wr_i;
          s_d.ce_n  = 1'b0;     // RULE1
          s_d.dq_oe = wr_i;
          s_d.st    = BC_SETUP;
        end
      end
      BC_SETUP: begin
        if (s_q.wr) begin
          s_d.we_n = 1'b0;      // RULE1
          s_d.cnt  = 4'(STROBE_CYC - 1);
        end else begin
          s_d.oe_n = 1'b0;
          s_d.cnt  = 4'(ACCESS_CYC - 1);
        end
        s_d.st = BC_ACT;
      end
      BC_ACT: begin
        if (s_q.cnt == 4'h0) begin
          if (s_q.wr) begin
            s_d.we_n = 1'b1;    // Data stays driven across this rising edge.
          end else begin
            s_d.oe_n  = 1'b1;
            s_d.rdata = flash_dq_i;
          end
          s_d.st = BC_HOLD;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      BC_HOLD: begin
        s_d.ce_n  = 1'b1;
        s_d.dq_oe = 1'b0;
        s_d.done  = 1'b1;
        s_d.st    = BC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= BC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign flash_ce_n_o  = s_q.ce_n;
  assign flash_oe_n_o  = s_q.oe_n;
  assign flash_we_n_o  = s_q.we_n;
  assign flash_addr_o  = s_q.addr;
  assign flash_dq_o    = s_q.dq;
  assign flash_dq_oe_o = s_q.dq_oe;
  assign rdata_o       = s_q.rdata;
  assign done_o        = s_q.done;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_WE_INSIDE_CE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE1
    !flash_we_n_o |-> !flash_ce_n_o && $past(!flash_ce_n_o))
    else $error("Write strobe low without chip select held low.");
  AST_WRITE_NO_OE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE1
    !flash_we_n_o |-> flash_oe_n_o && flash_dq_oe_o)
    else $error("Write strobe low while output enable low or data not driven.");
  AST_WRITE_STABLE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE1
    $rose(flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o) && flash_dq_oe_o)
    else $error("Address or data moved at the rising write strobe.");
  AST_NO_CONTENTION: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !flash_oe_n_o |-> !flash_dq_oe_o ##1 !flash_dq_oe_o)
    else $error("Host drives data while the flash outputs are enabled.");
endmodule

/* File: tb/pfc_flash_model.sv */
// Behavioural byte-wide flash for the host controller's bench.
// Assumes the host drives the pins from clk_sys_i, which also paces internal operations.
`timescale 1ns/1ps
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter int unsigned PROG_CYC  = 50,
  parameter int unsigned ERASE_CYC = 400,
  parameter int unsigned VALID_CYC = 10
) (
  input  wire logic              clk_sys_i,
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] dq_host_i,
  output logic      [DATA_W-1:0] dq_o
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  pd, last, val;
  logic [15:0] a_q, pa;
  logic [2:0]  step;
  logic [1:0]  kind;
  logic        tog;
  int          cnt, stl;
  // The array starts with a known pattern, so only addresses whose low byte is a5 read erased before any erase.
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
    step = 0;
    cnt = 0;
    kind = 0;
    tog = 0;
    last = 0;
  end
  // Address on the strobe fall, data and command decode on its rise.
  always @(negedge we_n_i) if (!ce_n_i && oe_n_i) a_q = addr_i;
  always @(posedge we_n_i) if (!ce_n_i && oe_n_i && cnt == 0) begin
    if (step == 6) kind = 1;
    else if (step == 5 && dq_host_i == CMD_SECTOR_ERASE) kind = 2;
    else if (step == 5 && a_q == CMD_ADDR_MAIN && dq_host_i == CMD_CHIP_ERASE) kind = 3;
    else kind = 0;
    pa = a_q;
    pd = dq_host_i;
    if (kind != 0) cnt = (kind == 1) ? PROG_CYC : ERASE_CYC;
    tog = 0;
    if (kind != 0) step = 0;
    else if (step == 2 && a_q == CMD_ADDR_MAIN && dq_host_i == 8'ha0) step = 6;
    else if (a_q == ((step == 1 || step == 4) ? 16'h2aaa : CMD_ADDR_MAIN) &&
             dq_host_i == ((step == 1 || step == 4) ? 8'h55 : (step == 2) ? 8'h80 : 8'haa)) step = step + 1;
    else step = 0;
  end
  // Internal operation runs a fixed time, then the array changes at once.
  // After a program only the top bit is trustworthy for a while; the lower bits read inverted.
  always @(posedge clk_sys_i) begin
    if (stl > 0) stl = stl - 1;
    if (cnt > 0) begin
      cnt = cnt - 1;
      if (cnt == 0 && kind == 1) mem[pa] = mem[pa] & pd;
      if (cnt == 0 && kind == 1) stl = VALID_CYC;
      if (cnt == 0 && kind > 1)
        for (int i = 0; i < 65536; i++) if (kind == 3 || i[15:12] == pa[15:12]) mem[i] = 8'hff;
    end
  end
  assign val = (cnt != 0) ? ((kind == 1) ? {~pd[7], tog, pd[5:0]} : {1'b0, tog, 6'h00}) :
               (stl > 0 && addr_i == pa) ? {mem[pa][7], ~mem[pa][6:0]} : mem[addr_i];
  // A released bus shows the inverse of the last value so a stale sample cannot pass.
  assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
  always @(negedge oe_n_i) if (!ce_n_i && cnt > 0) tog = ~tog;
  always @(posedge clk_sys_i) if (!ce_n_i && !oe_n_i) last <= val;
endmodule

/* File: tb/pfc_host_test.sv */
// Self-checking bench for the flash host controller against the flash model.
// Assumes the controller answers every request with one done_o pulse.
`timescale 1ns/1ps
module pfc_host_test;
  import pfc_pkg::*;
  logic clk_sys_i, rst_i, req_i, busy_o, done_o, err_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_dq_oe_o;
  pfc_op_t op_i;
  logic [15:0] addr_i, flash_addr_o;
  logic [7:0]  wdata_i, rdata_o, flash_dq_i, flash_dq_o, w;
  logic [9:0]  exp_q[$];
  logic [9:0]  e;
  int n_mismatch = 0, num_checks = 0, seed = 32'h41cb;
  pfc_host #(.ERASE_TIMEOUT_CYC(2000)) DUT (.clk_sys_i, .rst_i, .req_i, .op_i, .addr_i, .wdata_i, .busy_o, .done_o,
    .err_o, .rdata_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_addr_o, .flash_dq_i, .flash_dq_o,
    .flash_dq_oe_o);
  pfc_flash_model FM (.clk_sys_i(clk_sys_i), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .addr_i(flash_addr_o), .dq_host_i(flash_dq_o), .dq_o(flash_dq_i));
  initial begin
    clk_sys_i = 0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Expectation word: bit 9 asks for a data check, bit 8 is the error flag.
  always @(negedge clk_sys_i) if (done_o === 1'b1) begin
    e = exp_q.pop_front();
    cmp("err_o", {7'h00, e[8]}, {7'h00, err_o});
    cmp("busy_o", 8'h00, {7'h00, busy_o});
    if (e[9]) cmp("rdata_o", e[7:0], rdata_o);
  end
  // Strobe and output enable must never overlap a deselected or driven bus.
  always @(negedge clk_sys_i) begin
    if (flash_we_n_o === 1'b0) cmp("flash_ce_n_o", 8'h00, {7'h00, flash_ce_n_o});
    if (flash_oe_n_o === 1'b0) cmp("flash_dq_oe_o", 8'h00, {7'h00, flash_dq_oe_o});
  end
  task automatic do_op(input pfc_op_t o, input logic [15:0] a, input logic [7:0] d, input logic [9:0] ex);
    int k;
    exp_q.push_back(ex);
    @(posedge clk_sys_i);
    #1;
    req_i = 1;
    op_i = o;
    addr_i = a;
    wdata_i = d;
    @(posedge clk_sys_i);
    #1;
    // A stray request with another address while busy must be ignored.
    if (o != PFC_OP_PROG) begin
      addr_i = ~a;
      @(posedge clk_sys_i);
      #1;
    end
    req_i = 0;
    for (k = 0; k < 3000 && done_o !== 1'b1; k++) @(negedge clk_sys_i);
    if (k == 3000) cmp("done_o", 8'h01, 8'h00);
    $display("test op %0d at %h ended", o, a);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    rst_i = 1;
    req_i = 0;
    op_i = PFC_OP_READ;
    addr_i = 0;
    wdata_i = 0;
    w = 8'($random(seed));
    repeat (8) @(posedge clk_sys_i);
    #1 rst_i = 0;
    do_op(PFC_OP_READ, 16'h2345, 8'h00, {2'b10, 8'h1f});
    do_op(PFC_OP_PROG, 16'h1234, w, 10'h100);
    do_op(PFC_OP_SECTER, 16'h1234, 8'h00, 10'h000);
    do_op(PFC_OP_PROG, 16'h1234, w, {2'b10, w});
    do_op(PFC_OP_READ, 16'h1fff, 8'h00, {2'b10, 8'hff});
    do_op(PFC_OP_READ, 16'h2000, 8'h00, {2'b10, 8'h5a});
    do_op(PFC_OP_CHIPER, 16'h0000, 8'h00, 10'h000);
    w = 8'($random(seed));
    do_op(PFC_OP_PROG, 16'h8001, w, {2'b10, w});
    do_op(PFC_OP_READ, 16'hffff, 8'h00, {2'b10, 8'hff});
    give_verdict;
  end
endmodule
